// ===== rtl/cpusv_top.sv
// Processor supervisor: reset generator, early-warning pulse, watchdog.
// Assumes supply and sense comparator results arrive as async digital pins.
//
// Behaviour
// (R1) Reset output forced active while supply-fail indication is present.
// (R2) After supply returns, including power-up, hold reset at least 130 ms.
// (R3) Pushbutton input is active low and debounced before affecting reset.
// (R4) Press asserts reset; 130 ms hold starts when the button is released.
// (R5) Early warning comes from sense comparison, independent of reset path.
// (R6) Sense below trip pulses the interrupt output for at least 200 us.
// (R7) Below-trip sense must persist about 5 us before a pulse starts.
// (R8) No interrupt pulse starts until the supply has reached its trip level.
// (R9) Watchdog timing starts only when reset output becomes inactive.
// (R10) Strobe falling edge before timeout clears and restarts the watchdog.
// (R11) On watchdog expiry, status output is driven low for at least 130 ms.
// (R12) Processor must strobe at intervals of at most one second.
// (R13) Active-low reset output standard; active-high reset output offered.
// (R14) Intervals counted on a slow time base; inputs synchronised first.
// (R15) While reset is active the watchdog is cleared and status inactive.
`timescale 1ns/1ps
`default_nettype none

module cpusv_top #(
    parameter int unsigned RESET_HOLD_TK   = cpusv_pkg::RESET_HOLD_TK,
    parameter int unsigned WDOG_TIMEOUT_TK = cpusv_pkg::WDOG_TIMEOUT_TK,
    parameter int unsigned WDOG_HOLD_TK    = cpusv_pkg::WDOG_HOLD_TK,
    parameter int unsigned DEBOUNCE_TK     = cpusv_pkg::DEBOUNCE_TK,
    parameter int unsigned TICK_DIV        = cpusv_pkg::TICK_DIV
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic supply_ok,
    input  wire logic sense_ok,
    input  wire logic pushbutton_reset_n,
    input  wire logic watchdog_kick_n,
    output logic      cpu_reset_n,
    output logic      cpu_reset,
    output logic      early_warning_n,
    output logic      watchdog_expired_n
);

    localparam int unsigned CW = cpusv_pkg::CNT_W;
    localparam int unsigned DW = $clog2(TICK_DIV + 1);

    initial
    begin
        if (RESET_HOLD_TK < 1 || RESET_HOLD_TK >= (1 << CW) ||
            WDOG_TIMEOUT_TK < 1 || WDOG_TIMEOUT_TK >= (1 << CW) ||
            WDOG_HOLD_TK < 1 || WDOG_HOLD_TK >= (1 << CW) ||
            TICK_DIV < 1)
            $error("cpusv_top: interval parameters out of range");
    end

    // ---- Slow time base -------------------------------------------------
    logic [DW-1:0] div_q;
    logic [DW-1:0] div_d;
    logic          tick;

    // Free-running divider; tick is one clk wide
    always_comb
    begin
        tick  = (div_q == DW'(TICK_DIV - 1));
        div_d = tick ? '0 : div_q + DW'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= '0;
        else
            div_q <= div_d;
    end

    // ---- Input conditioning ---------------------------------------------
    logic supply_ok_f;
    logic sense_ok_f;
    logic button_n_f;
    logic kick_n_f;

    // Supply sync only; analog side already filters noise
    cpusv_filter #(.STABLE_TK(1), .RST_VAL(1'b0)) u_supply (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .pin_in  (supply_ok),
        .level_q (supply_ok_f)
    );

    // Sense must stay low ~5 us before it counts
    cpusv_filter #(.STABLE_TK(cpusv_pkg::SENSE_FILT_TK),
                   .RST_VAL(1'b1)) u_sense (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .pin_in  (sense_ok),
        .level_q (sense_ok_f)
    ); // [R7] [R14]

    // Pushbutton debounce
    cpusv_filter #(.STABLE_TK(DEBOUNCE_TK), .RST_VAL(1'b1)) u_button (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .pin_in  (pushbutton_reset_n),
        .level_q (button_n_f)
    ); // [R3] [R14]

    // Strobe only synchronised; a settled falling edge counts only in the watchdog count phase
    cpusv_filter #(.STABLE_TK(1), .RST_VAL(1'b1)) u_kick (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .pin_in  (watchdog_kick_n),
        .level_q (kick_n_f)
    ); // [R14]

    // ---- Reset generator ------------------------------------------------
    logic          rst_act_q;
    logic          rst_act_d;
    logic [CW-1:0] rst_cnt_q;
    logic [CW-1:0] rst_cnt_d;

    // Any source holds the counter at zero; release after full hold
    always_comb
    begin
        rst_act_d = rst_act_q;
        rst_cnt_d = rst_cnt_q;
        if (!supply_ok_f || !button_n_f)
        begin
            rst_act_d = 1'b1; // [R1] [R4]
            rst_cnt_d = '0;
        end
        else if (rst_act_q && tick)
        begin
            if (rst_cnt_q == CW'(RESET_HOLD_TK - 1))
                rst_act_d = 1'b0; // [R2] [R4]
            else
                rst_cnt_d = rst_cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_act_q <= 1'b1;
            rst_cnt_q <= '0;
        end
        else
        begin
            rst_act_q <= rst_act_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // Both polarities offered; boards pick one
    assign cpu_reset_n = ~rst_act_q; // [R13]
    assign cpu_reset   = rst_act_q;  // [R13]

    // ---- Early warning pulse --------------------------------------------
    logic          ew_act_q;
    logic          ew_act_d;
    logic          ew_arm_q;
    logic          ew_arm_d;
    logic [CW-1:0] ew_cnt_q;
    logic [CW-1:0] ew_cnt_d;

    // One pulse per low excursion; rearms when sense recovers
    always_comb
    begin
        ew_act_d = ew_act_q;
        ew_arm_d = ew_arm_q;
        ew_cnt_d = ew_cnt_q;
        if (sense_ok_f)
            ew_arm_d = 1'b1;
        if (ew_act_q)
        begin
            if (tick)
            begin
                if (ew_cnt_q == CW'(cpusv_pkg::ALERT_PULSE_TK - 1))
                    ew_act_d = 1'b0; // [R6]
                else
                    ew_cnt_d = ew_cnt_q + CW'(1);
            end
        end
        else if (!sense_ok_f && ew_arm_q && supply_ok_f) // [R5] [R8]
        begin
            ew_act_d = 1'b1;
            ew_arm_d = 1'b0;
            ew_cnt_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ew_act_q <= 1'b0;
            ew_arm_q <= 1'b1;
            ew_cnt_q <= '0;
        end
        else
        begin
            ew_act_q <= ew_act_d;
            ew_arm_q <= ew_arm_d;
            ew_cnt_q <= ew_cnt_d;
        end
    end

    assign early_warning_n = ~ew_act_q;

    // ---- Watchdog -------------------------------------------------------
    typedef enum logic [1:0] {
        CPUSV_WD_IDLE  = 2'b00,
        CPUSV_WD_COUNT = 2'b01,
        CPUSV_WD_FIRED = 2'b10
    } cpusv_wd_t;

    cpusv_wd_t     wd_st_q;
    cpusv_wd_t     wd_st_d;
    logic [CW-1:0] wd_cnt_q;
    logic [CW-1:0] wd_cnt_d;
    logic          kick_prev_q;
    logic          kick_fall;

    assign kick_fall = kick_prev_q & ~kick_n_f;

    // Counter shared by timeout and low-hold phases
    always_comb
    begin
        wd_st_d  = wd_st_q;
        wd_cnt_d = wd_cnt_q;
        if (rst_act_q)
        begin
            wd_st_d  = CPUSV_WD_IDLE; // [R15]
            wd_cnt_d = '0;
        end
        else
        begin
            unique case (wd_st_q)
                CPUSV_WD_IDLE:
                begin
                    wd_st_d  = CPUSV_WD_COUNT; // [R9]
                    wd_cnt_d = '0;
                end
                CPUSV_WD_COUNT:
                begin
                    if (kick_fall)
                        wd_cnt_d = '0; // [R10] [R12]
                    else if (tick)
                    begin
                        if (wd_cnt_q == CW'(WDOG_TIMEOUT_TK - 1))
                        begin
                            wd_st_d  = CPUSV_WD_FIRED; // [R11]
                            wd_cnt_d = '0;
                        end
                        else
                            wd_cnt_d = wd_cnt_q + CW'(1);
                    end
                end
                CPUSV_WD_FIRED:
                begin
                    // Strobes ignored while status is held low
                    if (tick)
                    begin
                        if (wd_cnt_q == CW'(WDOG_HOLD_TK - 1))
                        begin
                            wd_st_d  = CPUSV_WD_COUNT; // [R11]
                            wd_cnt_d = '0;
                        end
                        else
                            wd_cnt_d = wd_cnt_q + CW'(1);
                    end
                end
                default:
                begin
                    wd_st_d  = CPUSV_WD_IDLE;
                    wd_cnt_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wd_st_q     <= CPUSV_WD_IDLE;
            wd_cnt_q    <= '0;
            kick_prev_q <= 1'b1;
        end
        else
        begin
            wd_st_q     <= wd_st_d;
            wd_cnt_q    <= wd_cnt_d;
            kick_prev_q <= kick_n_f;
        end
    end

    assign watchdog_expired_n = (wd_st_q != CPUSV_WD_FIRED); // [R11] [R15]

endmodule // cpusv_top

`default_nettype wire

// ===== include/cpusv_pkg.sv
// Package for the processor supervisor: timing figures and derived counts.
// Assumes a 200 MHz system clock and a slow tick derived inside the block.
`default_nettype none
package cpusv_pkg;

    // System clock
    localparam int unsigned CLK_HZ          = 200_000_000;

    // Slow time base: one tick per microsecond
    localparam int unsigned TICK_NS         = 1000;
    localparam int unsigned TICK_DIV        = (CLK_HZ / 1_000_000) * TICK_NS
                                              / 1000;

    // Timed intervals in their own units
    localparam int unsigned RESET_HOLD_MS   = 130;
    localparam int unsigned ALERT_PULSE_US  = 200;
    localparam int unsigned SENSE_FILT_US   = 5;
    localparam int unsigned WDOG_TIMEOUT_MS = 1000;
    localparam int unsigned WDOG_HOLD_MS    = 130;
    localparam int unsigned DEBOUNCE_US     = 1000;

    // Same intervals in slow ticks (one tick per microsecond)
    localparam int unsigned RESET_HOLD_TK   = RESET_HOLD_MS * 1000;
    localparam int unsigned ALERT_PULSE_TK  = ALERT_PULSE_US;
    localparam int unsigned SENSE_FILT_TK   = SENSE_FILT_US;
    localparam int unsigned WDOG_TIMEOUT_TK = WDOG_TIMEOUT_MS * 1000;
    localparam int unsigned WDOG_HOLD_TK    = WDOG_HOLD_MS * 1000;
    localparam int unsigned DEBOUNCE_TK     = DEBOUNCE_US;

    // Width of the reset, warning and watchdog interval counters (filters size their own)
    localparam int unsigned CNT_W           = 20;

endpackage

`default_nettype wire

// ===== rtl/cpusv_filter.sv
// Input filter: two-flop synchroniser and a tick-counted stability filter.
// Assumes tick is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module cpusv_filter #(
    parameter int unsigned STABLE_TK = 5,
    parameter bit          RST_VAL   = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tick,
    input  wire logic pin_in,
    output logic      level_q
);

    localparam int unsigned W = $clog2(STABLE_TK + 1);

    initial
    begin
        if (STABLE_TK < 1)
            $error("cpusv_filter: STABLE_TK must be at least 1");
    end

    logic         meta_q;
    logic         sync_q;
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         level_d;

    // Next state: level moves only after STABLE_TK ticks of disagreement
    always_comb
    begin
        cnt_d   = cnt_q;
        level_d = level_q;
        if (sync_q == level_q)
            cnt_d = '0;
        else if (tick)
        begin
            if (cnt_q == W'(STABLE_TK - 1))
            begin
                level_d = sync_q;
                cnt_d   = '0;
            end
            else
                cnt_d = cnt_q + W'(1);
        end
    end

    // Synchroniser second flop is the only reader of the first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q  <= RST_VAL;
            sync_q  <= RST_VAL;
            cnt_q   <= '0;
            level_q <= RST_VAL;
        end
        else
        begin
            meta_q  <= pin_in;
            sync_q  <= meta_q;
            cnt_q   <= cnt_d;
            level_q <= level_d;
        end
    end

endmodule // cpusv_filter

`default_nettype wire

// ===== verification/cpusv_checker.sv
// Port checker for the supervisor top, bound below.
// Assumes the shortened tick counts handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
module cpusv_checker #(
    parameter int unsigned RESET_HOLD_TK   = 20,
    parameter int unsigned WDOG_TIMEOUT_TK = 50,
    parameter int unsigned WDOG_HOLD_TK    = 20,
    parameter int unsigned TICK_DIV        = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic sense_ok,
    input wire logic pushbutton_reset_n,
    input wire logic watchdog_kick_n,
    input wire logic cpu_reset_n,
    input wire logic cpu_reset,
    input wire logic early_warning_n,
    input wire logic watchdog_expired_n
);
    localparam int D = TICK_DIV;
    localparam int HOLD_C = RESET_HOLD_TK * D - D;
    localparam int FLT_C = 4 * D;
    localparam int PUL_C = 199 * D;
    localparam int TO_C = WDOG_TIMEOUT_TK * D - 2 * D;
    localparam int WH_C = WDOG_HOLD_TK * D - D;
    logic [15:0] good_q, slo_q, wlo_q, idle_q, wdl_q;
    // Cycle counts of the causes; 16 bits is ample for a short run
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            good_q <= '0;
            slo_q <= '0;
            wlo_q <= '0;
            idle_q <= '0;
            wdl_q <= '0;
        end
        else
        begin
            good_q <= (supply_ok && pushbutton_reset_n) ? good_q + 16'h0001 : '0;
            slo_q <= sense_ok ? '0 : slo_q + 16'h0001;
            wlo_q <= early_warning_n ? '0 : wlo_q + 16'h0001;
            wdl_q <= watchdog_expired_n ? '0 : wdl_q + 16'h0001;
            idle_q <= (!cpu_reset_n || $fell(watchdog_kick_n)) ?
                      '0 : idle_q + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_warn_start;
        $fell(early_warning_n);
    endsequence
    a_rst_pair: assert property (cpu_reset != cpu_reset_n)
        else $error("reset outputs disagree");
    a_supply_fail: assert property (!supply_ok [*8] |-> !cpu_reset_n)
        else $error("reset not forced by supply fail");
    a_hold_min: assert property
        ($rose(cpu_reset_n) |-> good_q >= HOLD_C)
        else $error("reset released too early");
    a_warn_filter: assert property
        (s_warn_start |-> slo_q >= FLT_C)
        else $error("warning without filtered sense");
    a_warn_supply: assert property (s_warn_start |-> supply_ok)
        else $error("warning while supply bad");
    a_warn_len: assert property
        ($rose(early_warning_n) |-> wlo_q >= PUL_C)
        else $error("warning pulse too short");
    a_wdog_quiet: assert property
        (!cpu_reset_n [*2] |-> watchdog_expired_n)
        else $error("watchdog active in reset");
    a_wdog_early: assert property
        ($fell(watchdog_expired_n) |-> idle_q >= TO_C)
        else $error("watchdog expired early");
    a_wdog_hold: assert property ($rose(watchdog_expired_n) && cpu_reset_n
        |-> wdl_q >= WH_C)
        else $error("watchdog status too short");
endmodule // cpusv_checker
bind cpusv_top cpusv_checker #(
    .RESET_HOLD_TK   (RESET_HOLD_TK),
    .WDOG_TIMEOUT_TK (WDOG_TIMEOUT_TK),
    .WDOG_HOLD_TK    (WDOG_HOLD_TK),
    .TICK_DIV        (TICK_DIV)
) u_chk (
    .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .sense_ok(sense_ok),
    .pushbutton_reset_n(pushbutton_reset_n),
    .watchdog_kick_n(watchdog_kick_n), .cpu_reset_n(cpu_reset_n),
    .cpu_reset(cpu_reset), .early_warning_n(early_warning_n),
    .watchdog_expired_n(watchdog_expired_n)
);
`default_nettype wire

// ===== verification/cpusv_cpu_model.sv
// Processor model: strobes the watchdog while out of reset.
// Assumes kick_en from the bench; idle strobe sits high like a pull-up.
`timescale 1ns/1ps
`default_nettype none
module cpusv_cpu_model #(
    parameter int unsigned PERIOD = 120
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic cpu_reset_n,
    input  wire logic kick_en,
    output logic      watchdog_kick_n
);
    logic       run;
    logic [7:0] cnt_q;
    // Kicks only while running, as software would
    assign run = cpu_reset_n && kick_en;
    // Period well inside the timeout
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else if (!run || cnt_q == 8'(PERIOD - 1))
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 8'h01;
    end
    // Low eight clocks: spans two shortened ticks, so it is never missed
    assign watchdog_kick_n = !(run && cnt_q < 8'h08);
endmodule // cpusv_cpu_model
`default_nettype wire

// ===== verification/cpu_supervisor_reset_watchdog_tb_top.sv
// Bench for the supervisor with shortened counts, tick every 4 clk.
// Assumes the checker is bound in and the processor model beside it.
`timescale 1ns/1ps
`default_nettype none
module cpu_supervisor_reset_watchdog_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sup = 1'b1;
    logic sen = 1'b1;
    logic pb_n = 1'b1;
    logic kick_en = 1'b1;
    wire logic kick_n, rn, r, ew_n, wd_n;
    int err_count = 0;
    int num_checks = 0;
    always #2.5 clk = ~clk;
    cpusv_top #(.RESET_HOLD_TK(20), .WDOG_TIMEOUT_TK(50), .WDOG_HOLD_TK(20),
        .DEBOUNCE_TK(3), .TICK_DIV(4)) dut (
        .clk(clk), .rst_n(rst_n), .supply_ok(sup), .sense_ok(sen),
        .pushbutton_reset_n(pb_n), .watchdog_kick_n(kick_n),
        .cpu_reset_n(rn), .cpu_reset(r), .early_warning_n(ew_n),
        .watchdog_expired_n(wd_n));
    cpusv_cpu_model u_cpu (.clk(clk), .rst_n(rst_n),
        .cpu_reset_n(rn), .kick_en(kick_en), .watchdog_kick_n(kick_n));
    task automatic chk(input logic s, input logic e, input string m);
        num_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // Inputs move 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rel_chk();
        cyc(60);
        chk(rn, 1'b0, "reset released early");
        cyc(140);
        chk(rn, 1'b1, "reset not released");
        chk(r, 1'b0, "high reset stuck");
    endtask
    task automatic t_supply();
        sup = 1'b0;
        cyc(10);
        chk(rn, 1'b0, "no reset on supply fail");
        chk(r, 1'b1, "high reset idle");
        chk(wd_n, 1'b1, "status active in reset");
        sup = 1'b1;
        rel_chk();
    endtask
    task automatic t_button();
        pb_n = 1'b0;
        cyc(4);
        pb_n = 1'b1;
        cyc(20);
        chk(rn, 1'b1, "bounce caused reset");
        pb_n = 1'b0;
        cyc(200);
        chk(rn, 1'b0, "press not held");
        pb_n = 1'b1;
        rel_chk();
    endtask
    task automatic t_warn();
        sen = 1'b0;
        cyc(8);
        sen = 1'b1;
        cyc(40);
        chk(ew_n, 1'b1, "glitch gave warning");
        sen = 1'b0;
        cyc(40);
        chk(ew_n, 1'b0, "no warning");
        cyc(700);
        chk(ew_n, 1'b0, "warning too short");
        sen = 1'b1;
        cyc(200);
        chk(ew_n, 1'b1, "warning stuck");
    endtask
    task automatic t_warn_sup();
        sup = 1'b0;
        sen = 1'b0;
        cyc(60);
        chk(ew_n, 1'b1, "warning with supply bad");
        sup = 1'b1;
        cyc(40);
        chk(ew_n, 1'b0, "held warning missing");
        cyc(900);
        sen = 1'b1;
        cyc(200);
    endtask
    task automatic t_wdog();
        cyc(600);
        chk(wd_n, 1'b1, "kicked watchdog fired");
        // Wait for a whole strobe pulse so the last kick is surely taken
        @(posedge kick_n);
        cyc(1);
        kick_en = 1'b0;
        cyc(190);
        chk(wd_n, 1'b1, "timeout too early");
        cyc(40);
        chk(wd_n, 1'b0, "no timeout");
        cyc(30);
        chk(wd_n, 1'b0, "status too short");
        cyc(100);
        chk(wd_n, 1'b1, "status stuck");
        kick_en = 1'b1;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Whole run is about 4k cycles; the limit leaves wide margin
    initial
    begin
        #100us;
        err_count++;
        finish_test();
    end
    initial
    begin
        cyc(20);
        rst_n = 1'b1;
        rel_chk();
        t_supply();
        t_button();
        t_warn();
        t_warn_sup();
        t_wdog();
        finish_test();
    end
endmodule // cpu_supervisor_reset_watchdog_tb_top
`default_nettype wire
